// ---- hw/quad_dac_consts.vh ----
/*
  Constants for the quad 12-bit DAC serial load and update logic:
  frame lengths, frame field positions, register selects, control
  fields, reset values and the check polynomial.
  Assumes it is included by bare name from the design files only.
*/
`ifndef QUAD_DAC_CONSTS_VH
`define QUAD_DAC_CONSTS_VH

// ==========================================================
// Frame lengths and field positions
// ==========================================================
`define FRAME_BITS        6'd24
`define FRAME_BITS_CHECK  6'd32
`define FRAME_BITS_OVER   6'd33
`define CMD_RW_BIT        23
`define CMD_HEAD_MSB      23
`define CMD_HEAD_LSB      16
`define CMD_DREG_MSB      20
`define CMD_DREG_LSB      18
`define CMD_CH_MSB        17
`define CMD_CH_LSB        16
`define CMD_CODE_MSB      15
`define CMD_CODE_LSB      4

// ==========================================================
// Register selects carried in the frame
// ==========================================================
`define DREG_DAC_DATA     3'h0
`define DREG_CLEAR_CODE   3'h3
`define DREG_CHAN_CTRL    3'h4

// ==========================================================
// Per-channel control fields and reset values
// ==========================================================
`define CTL_RANGE_MSB     2
`define CTL_RANGE_LSB     0
`define CTL_OUT_EN        3
`define CTL_CLEAR_EN      4
`define CTL_WIDTH         5
`define RANGE_0_TO_5V     3'h0
`define RANGE_FIRST_CUR   3'h4
`define CTRL_RESET        5'h00
`define CODE_RESET        12'h000
`define CLEAR_CODE_RESET  12'h000

// ==========================================================
// Packet check
// ==========================================================
`define CHECK_POLY        8'h07
`define CHECK_INIT        8'h00

`endif

// ---- hw/quad_dac_serial_load_update.v ----
/*
  Serial load and output update logic of a quad 12-bit DAC: frame
  reception, packet check, input and DAC code registers, individual
  and simultaneous update, clear, readback and switch decoding.
  Assumes all pins are asynchronous to clk and that the serial clock
  runs well below a quarter of clk, so that every edge is seen.
*/
// What this block does
// - Commands arrive as 24-bit words, most significant bit first.
// - Serial data is sampled on each falling shift clock edge.
// - With packet checking on, frames are 32 bits instead of 24.
// - Load pin low: addressed channel output updates when frame-select rises.
// - Load pin high: first write per channel counts; later ones only read back.
// - Load pin falling after frame-select high updates all channels together.
// - Top four code bits become a fifteen-switch thermometer pattern.
// - Lower eight code bits drive the eight ladder switches directly.
// - Strap low at power-up: voltage and current outputs both high impedance.
// - Strap high at power-up: voltage outputs pulled down, current outputs off.
// - After power-up outputs stay disabled with range 0 V to 5 V.
// - Clear codes reset to zero, so a clear drives clear-enabled channels to code zero.
// - Channel codes are always unsigned straight binary.
// - At most one of voltage or current output is enabled per channel.
// - Four low data bits are ignored; bipolar zero is code with top bit only.
// - Channel code is taken from frame bits 15 down to 4.
// - In 32-bit frames the last eight bits carry the check code.
`include "quad_dac_consts.vh"

module quad_dac_serial_load_update #(
  parameter CHANNELS = 4,
  parameter CODE_W   = 12,
  parameter SEGMENTS = 15,
  parameter LADDER_W = 8
) (
  input  wire                         clk,
  input  wire                         rst_n,
  input  wire                         sclk,
  input  wire                         frame_sel_n,
  input  wire                         sdin,
  input  wire                         load_outputs_n,
  input  wire                         clear_req,
  input  wire                         packet_check,
  input  wire                         power_on_output_strap,
  output reg                          sdo,
  output reg  [CHANNELS*SEGMENTS-1:0] segment_switches,
  output reg  [CHANNELS*LADDER_W-1:0] ladder_switches,
  output reg  [CHANNELS-1:0]          vout_en,
  output reg  [CHANNELS-1:0]          iout_en,
  output reg  [CHANNELS-1:0]          vout_pulldown,
  output reg  [CHANNELS*3-1:0]        range_sel,
  output reg                          frame_error
);

  // ==========================================================
  // Pin synchronisation and edge detection
  // ==========================================================
  wire [6:0] pins_s;
  wire       sclk_s;
  wire       fs_s;
  wire       sdin_s;
  wire       load_s;
  wire       clear_s;
  wire       check_s;
  wire       strap_s;
  reg        sclk_d;
  reg        fs_d;
  reg        load_d;
  reg        clear_d;

  // Idle levels are the reset values so no false edge appears at release.
  sync_two_ff #(
    .WIDTH   (7),
    .RST_VAL (7'h0B)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({power_on_output_strap, packet_check, clear_req, load_outputs_n,
                sdin, frame_sel_n, sclk}),
    .sync_out (pins_s)
  );

  assign sclk_s  = pins_s[0];
  assign fs_s    = pins_s[1];
  assign sdin_s  = pins_s[2];
  assign load_s  = pins_s[3];
  assign clear_s = pins_s[4];
  assign check_s = pins_s[5];
  assign strap_s = pins_s[6];

  // Previous synchronised levels, kept for edge finding.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d  <= 1'b1;
      fs_d    <= 1'b1;
      load_d  <= 1'b1;
      clear_d <= 1'b0;
    end else begin
      sclk_d  <= sclk_s;
      fs_d    <= fs_s;
      load_d  <= load_s;
      clear_d <= clear_s;
    end
  end

  wire sclk_fall  = sclk_d & ~sclk_s;
  wire sclk_rise  = ~sclk_d & sclk_s;
  wire fs_fall    = fs_d & ~fs_s;
  wire fs_rise    = ~fs_d & fs_s;
  wire load_fall  = load_d & ~load_s;
  wire clear_rise = ~clear_d & clear_s;

  // ==========================================================
  // Frame reception
  // ==========================================================
  reg [31:0] rx_shift;
  reg [5:0]  bit_cnt;

  // Data and clock share one synchroniser delay, so the sampled bit is the
  // one present at the falling edge.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= 32'h00000000;
      bit_cnt  <= 6'h00;
    end else if (fs_fall) begin
      bit_cnt <= 6'h00;
    end else if (!fs_s && sclk_fall) begin
      rx_shift <= {rx_shift[30:0], sdin_s};
      if (bit_cnt != `FRAME_BITS_OVER) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // Check code over the 24 command bits, most significant bit first.
  function [7:0] check_code;
    input [23:0] word;
    integer      i;
    reg   [7:0]  acc;
    reg          fb;
    begin
      acc = `CHECK_INIT;
      for (i = 23; i >= 0; i = i - 1) begin
        fb  = acc[7] ^ word[i];
        acc = {acc[6:0], 1'b0} ^ (fb ? `CHECK_POLY : 8'h00);
      end
      check_code = acc;
    end
  endfunction

  // Command and check fields of the finished frame.
  wire [23:0] cmd      = check_s ? rx_shift[31:8] : rx_shift[23:0];
  wire [7:0]  rx_check = rx_shift[7:0];
  wire [5:0]  need     = check_s ? `FRAME_BITS_CHECK : `FRAME_BITS;
  wire        len_ok   = (bit_cnt == need);
  wire        check_ok = !check_s || (check_code(cmd) == rx_check);
  wire        exec     = fs_rise && len_ok && check_ok;

  wire                cmd_read = cmd[`CMD_RW_BIT];
  wire [2:0]          cmd_dreg = cmd[`CMD_DREG_MSB:`CMD_DREG_LSB];
  wire [1:0]          cmd_ch   = cmd[`CMD_CH_MSB:`CMD_CH_LSB];
  // Low four data bits are dropped; codes stay unsigned binary.
  wire [CODE_W-1:0]   cmd_code = cmd[`CMD_CODE_MSB:`CMD_CODE_LSB];
  wire [`CTL_WIDTH-1:0] cmd_ctl = cmd[`CTL_WIDTH-1:0];

  // ==========================================================
  // Channel registers and update control
  // ==========================================================
  reg [CODE_W-1:0]     input_code [0:CHANNELS-1];
  reg [CODE_W-1:0]     dac_code   [0:CHANNELS-1];
  reg [CODE_W-1:0]     rb_code    [0:CHANNELS-1];
  reg [CODE_W-1:0]     clear_code [0:CHANNELS-1];
  reg [`CTL_WIDTH-1:0] chan_ctrl  [0:CHANNELS-1];
  reg [CHANNELS-1:0]   pending;
  integer              c;

  // A simultaneous update is applied first so that a write ending in the
  // same cycle still lands on top of it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= {CHANNELS{1'b0}};
      for (c = 0; c < CHANNELS; c = c + 1) begin
        input_code[c] <= `CODE_RESET;
        dac_code[c]   <= `CODE_RESET;
        rb_code[c]    <= `CODE_RESET;
        clear_code[c] <= `CLEAR_CODE_RESET;
        chan_ctrl[c]  <= `CTRL_RESET;
      end
    end else begin
      if (load_fall && fs_s) begin
        pending <= {CHANNELS{1'b0}};
        for (c = 0; c < CHANNELS; c = c + 1) begin
          dac_code[c] <= input_code[c];
        end
      end
      if (clear_rise) begin
        for (c = 0; c < CHANNELS; c = c + 1) begin
          if (chan_ctrl[c][`CTL_CLEAR_EN]) begin
            dac_code[c] <= clear_code[c];
          end
        end
      end
      if (exec && !cmd_read) begin
        if (cmd_dreg == `DREG_DAC_DATA) begin
          rb_code[cmd_ch] <= cmd_code;
          if (!load_s) begin
            input_code[cmd_ch] <= cmd_code;
            dac_code[cmd_ch]   <= cmd_code;
            pending[cmd_ch]    <= 1'b0;
          end else if (!pending[cmd_ch]) begin
            input_code[cmd_ch] <= cmd_code;
            pending[cmd_ch]    <= 1'b1;
          end
        end else if (cmd_dreg == `DREG_CLEAR_CODE) begin
          clear_code[cmd_ch] <= cmd_code;
        end else if (cmd_dreg == `DREG_CHAN_CTRL) begin
          chan_ctrl[cmd_ch] <= cmd_ctl;
        end
      end
    end
  end

  // ==========================================================
  // Readback
  // ==========================================================
  reg  [23:0]       tx_shift;
  reg  [CODE_W-1:0] rd_value;

  // Source of a read, selected by the register field.
  always @* begin
    rd_value = {CODE_W{1'b0}};
    if (cmd_dreg == `DREG_DAC_DATA) begin
      rd_value = rb_code[cmd_ch];
    end else if (cmd_dreg == `DREG_CLEAR_CODE) begin
      rd_value = clear_code[cmd_ch];
    end else if (cmd_dreg == `DREG_CHAN_CTRL) begin
      rd_value = {{(CODE_W-`CTL_WIDTH){1'b0}}, chan_ctrl[cmd_ch]};
    end
  end

  // A read frame loads the answer, which leaves during the next frame,
  // changing on rising edges so the host can take it on falling ones.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift    <= 24'h000000;
      sdo         <= 1'b0;
      frame_error <= 1'b0;
    end else begin
      if (fs_rise) begin
        frame_error <= ~(len_ok && check_ok);
        if (exec && cmd_read) begin
          tx_shift <= {cmd[`CMD_HEAD_MSB:`CMD_HEAD_LSB], rd_value, 4'h0};
        end else begin
          tx_shift <= 24'h000000;
        end
      end else if (fs_fall) begin
        sdo <= tx_shift[23];
      end else if (!fs_s && sclk_rise) begin
        tx_shift <= {tx_shift[22:0], 1'b0};
        sdo      <= tx_shift[22];
      end
    end
  end

  // ==========================================================
  // Power-on strap capture
  // ==========================================================
  reg [1:0] strap_wait;
  reg       strap_high;

  // The strap is caught once, after the synchroniser has filled.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait <= 2'h0;
      strap_high <= 1'b0;
    end else if (strap_wait != 2'h3) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        strap_high <= strap_s;
      end
    end
  end

  // ==========================================================
  // Switch decoding and output enables
  // ==========================================================
  integer s;
  integer k;

  // Outputs are registered; both output stages start off.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      segment_switches <= {(CHANNELS*SEGMENTS){1'b0}};
      ladder_switches  <= {(CHANNELS*LADDER_W){1'b0}};
      vout_en          <= {CHANNELS{1'b0}};
      iout_en          <= {CHANNELS{1'b0}};
      vout_pulldown    <= {CHANNELS{1'b0}};
      range_sel        <= {CHANNELS{`RANGE_0_TO_5V}};
    end else begin
      // A loop index of its own keeps this process from sharing a variable with another.
      for (k = 0; k < CHANNELS; k = k + 1) begin
        for (s = 0; s < SEGMENTS; s = s + 1) begin
          segment_switches[k*SEGMENTS+s] <=
            (dac_code[k][CODE_W-1:LADDER_W] > s);
        end
        ladder_switches[k*LADDER_W +: LADDER_W] <=
          dac_code[k][LADDER_W-1:0];
        range_sel[k*3 +: 3] <= chan_ctrl[k][`CTL_RANGE_MSB:`CTL_RANGE_LSB];
        vout_en[k] <= chan_ctrl[k][`CTL_OUT_EN] &&
          (chan_ctrl[k][`CTL_RANGE_MSB:`CTL_RANGE_LSB] < `RANGE_FIRST_CUR);
        iout_en[k] <= chan_ctrl[k][`CTL_OUT_EN] &&
          (chan_ctrl[k][`CTL_RANGE_MSB:`CTL_RANGE_LSB] >= `RANGE_FIRST_CUR);
        // A disabled voltage output rests on the pull-down only with strap high.
        vout_pulldown[k] <= strap_high && !chan_ctrl[k][`CTL_OUT_EN];
      end
    end
  end

endmodule // quad_dac_serial_load_update

// ---- hw/sync_two_ff.v ----
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level or a clock far slower than clk;
  bits are not coherent with each other across the crossing.
*/
module sync_two_ff #(
  parameter            WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sync_two_ff

// ---- tb/quad_dac_checker.sv ----
/* Output relations of the quad DAC load and update block.
   Assumes it is bound to the block's top module and that the strap only
   changes while reset is held. */
module quad_dac_checker #(
  parameter CHANNELS = 4,
  parameter SEGMENTS = 15,
  parameter LADDER_W = 8
) (
  input logic                         clk,
  input logic                         rst_n,
  input logic                         sclk,
  input logic                         frame_sel_n,
  input logic                         sdin,
  input logic                         load_outputs_n,
  input logic                         clear_req,
  input logic                         packet_check,
  input logic                         power_on_output_strap,
  input logic                         sdo,
  input logic [CHANNELS*SEGMENTS-1:0] segment_switches,
  input logic [CHANNELS*LADDER_W-1:0] ladder_switches,
  input logic [CHANNELS-1:0]          vout_en,
  input logic [CHANNELS-1:0]          iout_en,
  input logic [CHANNELS-1:0]          vout_pulldown,
  input logic [CHANNELS*3-1:0]        range_sel,
  input logic                         frame_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] since_end;
  logic [3:0] since_evt;
  logic       fs_q, ld_q, cl_q;
  wire        fs_rise = frame_sel_n & !fs_q;
  wire        any_evt = fs_rise | (!load_outputs_n & ld_q) | (clear_req & !cl_q);

  // ==========================================================
  // Helper counters
  // ==========================================================
  // Cycles since a pin event; reset counts as one, since a sync may see a frame end.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {fs_q, ld_q, cl_q} <= 3'b110;
      since_end <= 4'h0;
      since_evt <= 4'h0;
    end else begin
      {fs_q, ld_q, cl_q} <= {frame_sel_n, load_outputs_n, clear_req};
      since_end <= fs_rise ? 4'h0 : since_end + {3'h0, since_end != 4'hF};
      since_evt <= any_evt ? 4'h0 : since_evt + {3'h0, since_evt != 4'hF};
    end
  end

  // Every channel's segment group must be a thermometer pattern.
  function automatic bit thermo_ok(input logic [CHANNELS*SEGMENTS-1:0] s);
    logic [SEGMENTS-1:0] f;
    thermo_ok = 1'b1;
    for (int c = 0; c < CHANNELS; c++) begin
      f = s[c*SEGMENTS +: SEGMENTS];
      if ((f & (f + 1'b1)) != '0) thermo_ok = 1'b0;
    end
  endfunction

  // A voltage output needs a voltage range, a current output a current range.
  function automatic bit kind_ok(input logic [CHANNELS-1:0] v, input logic [CHANNELS-1:0] i,
                                 input logic [CHANNELS*3-1:0] r);
    kind_ok = 1'b1;
    for (int c = 0; c < CHANNELS; c++)
      if ((v[c] && r[c*3+2]) || (i[c] && !r[c*3+2])) kind_ok = 1'b0;
  endfunction

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_one_output; (vout_en & iout_en) == '0; endproperty
  a_one_output: assert property (p_one_output) else $error("both outputs on");
  property p_out_kind; since_evt > 4'd12 |-> kind_ok(vout_en, iout_en, range_sel); endproperty
  a_out_kind: assert property (p_out_kind) else $error("output kind vs range");
  property p_thermo; thermo_ok(segment_switches); endproperty
  a_thermo: assert property (p_thermo) else $error("segments not thermometer");
  property p_reset_zero;
    $rose(rst_n) |-> {segment_switches, ladder_switches, vout_en, iout_en, range_sel} == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not idle");
  property p_pd_strap;
    $rose(rst_n) && power_on_output_strap |-> ##[2:6] vout_pulldown == {CHANNELS{1'b1}};
  endproperty
  a_pd_strap: assert property (p_pd_strap) else $error("pull-downs missing");
  property p_pd_only_strap; vout_pulldown != '0 |-> power_on_output_strap; endproperty
  a_pd_only_strap: assert property (p_pd_only_strap) else $error("pull-down, strap low");
  property p_pd_excl; since_evt > 4'd12 |-> (vout_pulldown & (vout_en | iout_en)) == '0; endproperty
  a_pd_excl: assert property (p_pd_excl) else $error("pull-down on live output");
  property p_quiet;
    since_evt > 4'd12 |=> $stable(ladder_switches) && $stable(segment_switches)
      && $stable(vout_en) && $stable(iout_en);
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs moved without cause");
  property p_err_moment; $changed(frame_error) |-> since_end < 4'd10; endproperty
  a_err_moment: assert property (p_err_moment) else $error("frame error off frame end");

  c_check_frame: cover property (packet_check && fs_rise);
  c_refused: cover property ($rose(frame_error));
  c_current: cover property (iout_en != '0);
endmodule // quad_dac_checker

bind quad_dac_serial_load_update quad_dac_checker #(
  .CHANNELS(CHANNELS), .SEGMENTS(SEGMENTS), .LADDER_W(LADDER_W)
) i_chk (.clk, .rst_n, .sclk, .frame_sel_n, .sdin, .load_outputs_n, .clear_req, .packet_check,
  .power_on_output_strap, .sdo, .segment_switches, .ladder_switches, .vout_en, .iout_en,
  .vout_pulldown, .range_sel, .frame_error);

// ---- tb/serial_host.sv ----
/* Host model: sends frames on the serial pins and collects readback bits.
   Assumes the caller spaces its frames and owns the load and clear pins. */
module serial_host (
  output logic sclk,
  output logic frame_sel_n,
  output logic sdin,
  input  logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx;

  // Idle pins; the shift clock stands still outside frames.
  initial begin
    sclk = 1'b1;
    frame_sel_n = 1'b1;
    sdin = 1'b0;
    rx = '0;
  end

  // Check byte over the 24 command bits, most significant bit first.
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // One frame; flip spoils the check byte, drop cuts bits from the tail.
  task automatic xfer(input logic [23:0] cmd, input logic chk, input logic [7:0] flip,
                      input int drop);
    logic [31:0] w;
    int          top;
    w = chk ? {cmd, crc8(cmd) ^ flip} : {8'h00, cmd};
    top = chk ? 31 : 23;
    #5.5 frame_sel_n = 1'b0;
    for (int i = top; i >= drop; i--) begin
      sdin = w[i];
      #80 sclk = 1'b0;
      rx = {rx[30:0], sdo};
      #80 sclk = 1'b1;
    end
    #80 frame_sel_n = 1'b1;
    sdin = ~sdin;
    #160;
  endtask
endmodule // serial_host

// ---- tb/tb.sv ----
/* Self-checking bench for the quad DAC load and update block.
   Assumes the block's default widths and the host model in serial_host. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, ldn = 1'b0, clr = 1'b0, pc = 1'b0, strap = 1'b0;
  wire         sclk, fsn, sdin, sdo, ferr;
  wire  [59:0] seg;
  wire  [31:0] lad;
  wire  [3:0]  ven, ien, vpd;
  wire  [11:0] rng;
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  logic [31:0] seed = 32'h0000D986;
  logic [11:0] v, a, b, g, last [4];
  logic [23:0] c;
  logic [11:0] corner [3] = '{12'h000, 12'hFFF, 12'h800};
  logic [7:0]  flp [4] = '{8'h00, 8'h01, 8'h00, 8'h00};
  int          drp [4] = '{0, 0, 8, 1};
  logic        pcs [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  quad_dac_serial_load_update i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .frame_sel_n(fsn),
    .sdin(sdin), .load_outputs_n(ldn), .clear_req(clr), .packet_check(pc),
    .power_on_output_strap(strap), .sdo(sdo), .segment_switches(seg), .ladder_switches(lad),
    .vout_en(ven), .iout_en(ien), .vout_pulldown(vpd), .range_sel(rng), .frame_error(ferr));
  serial_host i_host (.sclk(sclk), .frame_sel_n(fsn), .sdin(sdin), .sdo(sdo));

  // 125 MHz clock; the cycle ceiling cuts a hang short.
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected thermometer and frame builder; low four bits are random filler.
  function automatic logic [14:0] therm(input logic [3:0] t);
    for (int s = 0; s < 15; s++) therm[s] = (t > s);
  endfunction
  function automatic logic [23:0] cmd(input logic rd, input logic [2:0] r, input logic [1:0] ch,
                                      input logic [11:0] x);
    return {rd, 2'b00, r, ch, x, 4'(rnd())};
  endfunction

  task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_ch(input int ch, input logic [11:0] x);
    check("segments", seg[ch*15 +: 15], therm(x[11:8]));
    check("ladder", lad[ch*8 +: 8], x[7:0]);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence: power-up states, both update modes, refusals, control and clear.
  initial begin
    for (int s = 0; s < 2; s++) begin
      rst_n = 1'b0;
      strap = s[0];
      w(10);
      rst_n = 1'b1;
      #100us;
      check("pulldown", vpd, {4{s[0]}});
      check("enables", {ven, ien, rng}, 20'h00000);
    end
    $display("Test power-up done");
    for (int i = 0; i < 10; i++) begin
      v = (i < 3) ? corner[i] : 12'(rnd());
      i_host.xfer(cmd(1'b0, 3'h0, 2'(i), v), 1'b0, 8'h00, 0);
      w(4);
      last[i % 4] = v;
      chk_ch(i % 4, v);
    end
    $display("Test individual update done");
    ldn = 1'b1;
    a = 12'(rnd());
    b = ~a;
    i_host.xfer(cmd(1'b0, 3'h0, 2'h0, a), 1'b0, 8'h00, 0);
    i_host.xfer(cmd(1'b0, 3'h0, 2'h0, b), 1'b0, 8'h00, 0);
    w(4);
    chk_ch(0, last[0]);
    c = cmd(1'b1, 3'h0, 2'h0, 12'h000);
    i_host.xfer(c, 1'b0, 8'h00, 0);
    i_host.xfer(c, 1'b0, 8'h00, 0);
    check("readback", i_host.rx[23:0], {c[23:16], b, 4'h0});
    w(1);
    ldn = 1'b0;
    w(8);
    chk_ch(0, a);
    $display("Test simultaneous update done");
    g = last[1];
    for (int k = 0; k < 4; k++) begin
      pc = pcs[k];
      v = 12'(rnd());
      i_host.xfer(cmd(1'b0, 3'h0, 2'h1, v), pcs[k], flp[k], drp[k]);
      w(4);
      if (k == 0) g = v;
      check("frame_error", ferr, k != 0);
      chk_ch(1, g);
    end
    pc = 1'b0;
    $display("Test packet check done");
    // Control values sit in the low five data bits; bit 4 is also the lowest code field bit.
    i_host.xfer({1'b0, 2'b00, 3'h4, 2'h2, 16'h001C}, 1'b0, 8'h00, 0);
    i_host.xfer({1'b0, 2'b00, 3'h4, 2'h3, 16'h0008}, 1'b0, 8'h00, 0);
    i_host.xfer(cmd(1'b0, 3'h0, 2'h2, 12'hFFF), 1'b0, 8'h00, 0);
    w(4);
    check("control", {ven, ien, vpd, rng}, 24'h843100);
    clr = 1'b1;
    w(8);
    chk_ch(2, 12'h000);
    chk_ch(3, last[3]);
    clr = 1'b0;
    $display("Test control and clear done");
    print_verdict();
  end
endmodule // tb
